/* File: pkg/adc_cal_pkg.sv */
package adc_cal_pkg;

	// register indices; byte address is four times the index
	localparam int unsigned IDX_CH1_GAIN_CAL_HIGH = 'h11;
	localparam int unsigned IDX_CH1_GAIN_CAL_LOW = 'h12;
	localparam int unsigned IDX_CH2_CONFIG = 'h13;
	localparam int unsigned IDX_CH2_OFFSET_CAL_HIGH = 'h14;
	localparam int unsigned IDX_CH2_OFFSET_CAL_LOW = 'h15;
	localparam int unsigned IDX_CH2_GAIN_CAL_HIGH = 'h16;
	localparam int unsigned IDX_FIRST = IDX_CH1_GAIN_CAL_HIGH;
	localparam int unsigned BYTES_PER_REG = 4;

	// slot numbers inside the bank, slot = index - IDX_FIRST
	localparam int unsigned REG_COUNT = 6;
	localparam int unsigned SLOT_CH1_GAIN_HIGH = IDX_CH1_GAIN_CAL_HIGH - IDX_FIRST;
	localparam int unsigned SLOT_CH1_GAIN_LOW = IDX_CH1_GAIN_CAL_LOW - IDX_FIRST;
	localparam int unsigned SLOT_CH2_CONFIG = IDX_CH2_CONFIG - IDX_FIRST;
	localparam int unsigned SLOT_CH2_OFFSET_HIGH = IDX_CH2_OFFSET_CAL_HIGH - IDX_FIRST;
	localparam int unsigned SLOT_CH2_OFFSET_LOW = IDX_CH2_OFFSET_CAL_LOW - IDX_FIRST;
	localparam int unsigned SLOT_CH2_GAIN_HIGH = IDX_CH2_GAIN_CAL_HIGH - IDX_FIRST;

	localparam int unsigned REG_W = 16;
	localparam int unsigned COEF_W = 24;

	// reset values, slot 5 first
	localparam logic [REG_COUNT-1:0][REG_W-1:0] REG_RESET = {
		16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000
	};
	// writable bits; reserved bits are zero here
	localparam logic [REG_COUNT-1:0][REG_W-1:0] REG_WMASK = {
		16'hFFFF, 16'hFF00, 16'hFFFF, 16'hFFF7, 16'hFF00, 16'hFFFF
	};

	// channel 2 configuration fields
	localparam int unsigned CFG_DELAY_MSB = 15;
	localparam int unsigned CFG_DELAY_LSB = 6;
	localparam int unsigned CFG_DELAY_W = CFG_DELAY_MSB - CFG_DELAY_LSB + 1;
	localparam int unsigned CFG_TEMP_SOURCE_BIT = 5;
	localparam int unsigned CFG_TEMP_ON_BIT = 4;
	localparam int unsigned CFG_TEMP_INVERT_BIT = 2;
	localparam int unsigned CFG_ROUTE_MSB = 1;
	localparam int unsigned CFG_ROUTE_LSB = 0;

	// low-register coefficient byte position
	localparam int unsigned LOW_COEF_MSB = 15;
	localparam int unsigned LOW_COEF_LSB = 8;

	// input routes
	localparam logic [1:0] ROUTE_NORMAL = 2'h0;
	localparam logic [1:0] ROUTE_SHORTED = 2'h1;
	localparam logic [1:0] ROUTE_DC_TEST = 2'h2;
	localparam logic [1:0] ROUTE_AC_TEST = 2'h3;

	// sample delay bias turns the signed count into a wait of 0..1023 ticks
	localparam logic [10:0] DELAY_BIAS = 11'h200;
	localparam int unsigned MOD_DIV_DEFAULT = 32;

	// gain 1.0 is 2^23, so products shift right by this much
	localparam int unsigned GAIN_FRAC_BITS = 23;

endpackage : adc_cal_pkg

/* File: rtl/cal_word.sv */
`timescale 1ns/10ps

module cal_word
	import adc_cal_pkg::*;
#(
	parameter logic [15:0] RESET_VALUE = 16'h0000,
	parameter logic [15:0] WRITE_MASK = 16'hFFFF
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	input wire logic [1:0] byte_en,
	output logic [15:0] value
);

	typedef struct packed {
		logic [15:0] value;
	} word_state_t;

	word_state_t state_reg;
	word_state_t state_next;
	logic [15:0] lane_mask;

	assign lane_mask = {{8{byte_en[1]}}, {8{byte_en[0]}}} & WRITE_MASK;

	always_comb begin
		state_next = state_reg;
		if (wr_en) begin
			// reserved bits never take written data
			state_next.value = (state_reg.value & ~lane_mask) | (wr_data & lane_mask);
		end
		state_next.value = state_next.value & WRITE_MASK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '{value: RESET_VALUE};
		end else begin
			state_reg <= state_next;
		end
	end

	assign value = state_reg.value;

endmodule : cal_word

/* File: rtl/adc_cal_regs.sv */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps


module adc_cal_regs
	import adc_cal_pkg::*;
#(
	parameter int unsigned ADDR_W = 8,
	parameter int unsigned MOD_DIV = MOD_DIV_DEFAULT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frame_start,
	input wire logic ch2_raw_valid,
	input wire logic [23:0] ch2_raw_data,
	output logic [23:0] ch1_gain_coef,
	output logic [23:0] ch2_offset_coef,
	output logic [23:0] ch2_gain_coef,
	output logic [9:0] ch2_sample_delay,
	output logic temp_source_choice,
	output logic temp_measure_on,
	output logic temp_input_invert,
	output logic [1:0] ch2_input_route,
	output logic mod_tick,
	output logic ref_sample_strobe,
	output logic ch2_sample_strobe,
	output logic ch2_cal_valid,
	output logic [23:0] ch2_cal_data
);

	localparam int unsigned DIV_W = (MOD_DIV > 1) ? $clog2(MOD_DIV) : 1;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MOD_DIV - 1);
	localparam int unsigned TOP_BYTE_ADDR = BYTES_PER_REG * (IDX_FIRST + REG_COUNT - 1);

	generate
		if (ADDR_W < $clog2(TOP_BYTE_ADDR + 1) || ADDR_W > 32) begin : g_bad_addr_w
			$error("adc_cal_regs: ADDR_W cannot reach the register bank");
		end
		if (MOD_DIV < 2) begin : g_bad_mod_div
			$error("adc_cal_regs: MOD_DIV must be at least 2");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// register bank

	logic [REG_COUNT-1:0][REG_W-1:0] reg_value;
	logic [REG_COUNT-1:0] addr_hit;
	logic [REG_COUNT-1:0] reg_wr;
	logic access_done;
	logic setup_phase;

	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready;

	genvar gi;
	generate
		for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
			assign addr_hit[gi] = (paddr == ADDR_W'(BYTES_PER_REG * (IDX_FIRST + gi)));
			// write lands only on the completing access edge
			assign reg_wr[gi] = access_done && pwrite && addr_hit[gi];

			cal_word #(
				.RESET_VALUE(REG_RESET[gi]),
				.WRITE_MASK(REG_WMASK[gi])
			) u_word (
				.pclk(pclk),
				.presetn(presetn),
				.wr_en(reg_wr[gi]),
				.wr_data(pwdata[15:0]),
				.byte_en(pstrb[1:0]),
				.value(reg_value[gi])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// coefficient and field views, straight from register bits except the constant zero low byte of ch2_gain_coef

	assign ch1_gain_coef = {reg_value[SLOT_CH1_GAIN_HIGH],
		reg_value[SLOT_CH1_GAIN_LOW][LOW_COEF_MSB:LOW_COEF_LSB]};
	assign ch2_offset_coef = {reg_value[SLOT_CH2_OFFSET_HIGH],
		reg_value[SLOT_CH2_OFFSET_LOW][LOW_COEF_MSB:LOW_COEF_LSB]};
	// channel 2 gain-low lives outside this bank, so its low byte is zero here
	assign ch2_gain_coef = {reg_value[SLOT_CH2_GAIN_HIGH], 8'h00};
	assign ch2_sample_delay = reg_value[SLOT_CH2_CONFIG][CFG_DELAY_MSB:CFG_DELAY_LSB];
	assign temp_source_choice = reg_value[SLOT_CH2_CONFIG][CFG_TEMP_SOURCE_BIT];
	assign temp_measure_on = reg_value[SLOT_CH2_CONFIG][CFG_TEMP_ON_BIT];
	assign temp_input_invert = reg_value[SLOT_CH2_CONFIG][CFG_TEMP_INVERT_BIT];
	assign ch2_input_route = reg_value[SLOT_CH2_CONFIG][CFG_ROUTE_MSB:CFG_ROUTE_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [DIV_W-1:0] div_cnt;
		logic mod_tick;
		logic [10:0] ref_cnt;
		logic ref_busy;
		logic ref_strobe;
		logic [10:0] ch2_cnt;
		logic ch2_busy;
		logic ch2_strobe;
		logic diff_valid;
		logic [24:0] diff;
		logic cal_valid;
		logic [23:0] cal_data;
	} top_state_t;

	top_state_t state_reg;
	top_state_t state_next;

	logic [15:0] read_word;
	logic [10:0] ch2_wait;
	logic signed [24:0] diff_s;
	logic signed [24:0] gain_s;
	logic signed [49:0] product;
	logic signed [26:0] scaled;
	logic scaled_overflow;

	always_comb begin
		read_word = 16'h0000;
		for (int i = 0; i < REG_COUNT; i++) begin
			if (addr_hit[i]) begin
				read_word = reg_value[i];
			end
		end
	end

	// signed delay plus bias: -512 fires at once, +511 waits 1023 ticks
	assign ch2_wait = DELAY_BIAS + {{1{ch2_sample_delay[9]}}, ch2_sample_delay};

	// gain is unsigned, so it gets a zero sign bit before the signed multiply
	assign diff_s = state_reg.diff;
	assign gain_s = {1'b0, ch2_gain_coef};
	assign product = diff_s * gain_s;
	assign scaled = product[GAIN_FRAC_BITS+26:GAIN_FRAC_BITS];
	assign scaled_overflow = (scaled[26:23] != {4{scaled[23]}});

	always_comb begin
		state_next = state_reg;

		// apb: setup cycle prepares the answer, access cycle completes it
		state_next.pready = 1'b0;
		if (setup_phase) begin
			state_next.pready = 1'b1;
			state_next.pslverr = ~|addr_hit;
			state_next.prdata = (!pwrite && |addr_hit) ? {16'h0000, read_word} : 32'h0000_0000;
		end else if (access_done) begin
			state_next.pslverr = 1'b0;
		end

		// modulator tick divider
		state_next.mod_tick = 1'b0;
		if (state_reg.div_cnt == DIV_LAST) begin
			state_next.div_cnt = '0;
			state_next.mod_tick = 1'b1;
		end else begin
			state_next.div_cnt = state_reg.div_cnt + DIV_W'(1);
		end

		// reference and channel 2 sample timing
		state_next.ref_strobe = 1'b0;
		state_next.ch2_strobe = 1'b0;
		if (frame_start) begin
			// a new frame restarts both waits
			state_next.ref_cnt = DELAY_BIAS;
			state_next.ref_busy = 1'b1;
			state_next.ch2_cnt = ch2_wait;
			state_next.ch2_busy = 1'b1;
		end else begin
			if (state_reg.ref_busy) begin
				if (state_reg.ref_cnt == 11'h000) begin
					state_next.ref_strobe = 1'b1;
					state_next.ref_busy = 1'b0;
				end else if (state_reg.mod_tick) begin
					state_next.ref_cnt = state_reg.ref_cnt - 11'h001;
				end
			end
			if (state_reg.ch2_busy) begin
				if (state_reg.ch2_cnt == 11'h000) begin
					state_next.ch2_strobe = 1'b1;
					state_next.ch2_busy = 1'b0;
				end else if (state_reg.mod_tick) begin
					state_next.ch2_cnt = state_reg.ch2_cnt - 11'h001;
				end
			end
		end

		// channel 2 calibration: (raw - offset) * gain, saturated
		state_next.diff_valid = ch2_raw_valid;
		if (ch2_raw_valid) begin
			state_next.diff = {ch2_raw_data[23], ch2_raw_data}
				- {ch2_offset_coef[23], ch2_offset_coef};
		end
		state_next.cal_valid = state_reg.diff_valid;
		if (state_reg.diff_valid) begin
			if (scaled_overflow) begin
				state_next.cal_data = scaled[26] ? 24'h800000 : 24'h7FFFFF;
			end else begin
				state_next.cal_data = scaled[23:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata = state_reg.prdata;
	assign pready = state_reg.pready;
	assign pslverr = state_reg.pslverr;
	assign mod_tick = state_reg.mod_tick;
	assign ref_sample_strobe = state_reg.ref_strobe;
	assign ch2_sample_strobe = state_reg.ch2_strobe;
	assign ch2_cal_valid = state_reg.cal_valid;
	assign ch2_cal_data = state_reg.cal_data;

endmodule : adc_cal_regs

/* File: sim/adc_cal_regs_asserts.sv */
`timescale 1ns/10ps

module adc_cal_regs_asserts
	import adc_cal_pkg::*;
#(
	parameter int unsigned ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic [23:0] ch1_gain_coef,
	input wire logic [23:0] ch2_offset_coef,
	input wire logic [23:0] ch2_gain_coef,
	input wire logic [9:0] ch2_sample_delay,
	input wire logic temp_source_choice,
	input wire logic temp_measure_on,
	input wire logic temp_input_invert,
	input wire logic [1:0] ch2_input_route
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] cfg_view;
	assign cfg_view = {ch2_sample_delay, temp_source_choice, temp_measure_on, 1'h0, temp_input_invert, ch2_input_route};
	sequence s_rd(logic [7:0] a);
		psel && penable && pready && !pwrite && paddr == a;
	endsequence
	sequence s_wr(logic [7:0] a);
		psel && penable && pready && pwrite && pstrb == 4'hF && paddr == a;
	endsequence
	property p_g1h; s_rd(8'h44) |-> prdata[15:0] == ch1_gain_coef[23:8]; endproperty
	a_g1h: assert property (p_g1h) else $error("gain1 high read");
	property p_g1l; s_rd(8'h48) |-> prdata[15:0] == {ch1_gain_coef[7:0], 8'h00}; endproperty
	a_g1l: assert property (p_g1l) else $error("gain1 low read");
	property p_cfgr; s_rd(8'h4C) |-> prdata[15:0] == cfg_view; endproperty
	a_cfgr: assert property (p_cfgr) else $error("config read");
	property p_ofh; s_rd(8'h50) |-> prdata[15:0] == ch2_offset_coef[23:8]; endproperty
	a_ofh: assert property (p_ofh) else $error("offset high read");
	property p_ofl; s_rd(8'h54) |-> prdata[15:0] == {ch2_offset_coef[7:0], 8'h00}; endproperty
	a_ofl: assert property (p_ofl) else $error("offset low read");
	property p_g2h; s_rd(8'h58) |-> prdata[15:0] == ch2_gain_coef[23:8]; endproperty
	a_g2h: assert property (p_g2h) else $error("gain2 high read");
	property p_rst; $rose(presetn) |-> ch1_gain_coef == 24'h800000 && ch2_gain_coef == 24'h800000
		&& ch2_offset_coef == 24'h000000; endproperty
	a_rst: assert property (p_rst) else $error("coefficients after reset");
	property p_cfgw; s_wr(8'h4C) |=> cfg_view == ($past(pwdata[15:0]) & 16'hFFF7); endproperty
	a_cfgw: assert property (p_cfgw) else $error("config write");
	property p_g1w; s_wr(8'h44) |=> ch1_gain_coef[23:8] == $past(pwdata[15:0]); endproperty
	a_g1w: assert property (p_g1w) else $error("gain1 write");
endmodule : adc_cal_regs_asserts

bind adc_cal_regs adc_cal_regs_asserts #(.ADDR_W(ADDR_W)) adc_cal_regs_asserts_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .ch1_gain_coef(ch1_gain_coef),
	.ch2_offset_coef(ch2_offset_coef), .ch2_gain_coef(ch2_gain_coef), .ch2_sample_delay(ch2_sample_delay),
	.temp_source_choice(temp_source_choice), .temp_measure_on(temp_measure_on),
	.temp_input_invert(temp_input_invert), .ch2_input_route(ch2_input_route));

/* File: sim/apb_host.sv */
`timescale 1ns/10ps

module apb_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	// left open so a following setup can start at the same edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
	endtask : xfer
	task automatic idle();
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : idle
endmodule : apb_host

/* File: sim/testbench.sv */
`timescale 1ns/10ps

module testbench;
	import adc_cal_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_start, ch2_raw_valid, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [23:0] ch2_raw_data, ch1_gain_coef, ch2_offset_coef, ch2_gain_coef;
	logic [9:0] ch2_sample_delay;
	logic temp_source_choice, temp_measure_on, temp_input_invert;
	logic [1:0] ch2_input_route;
	logic [15:0] v;
	logic mod_tick, ref_sample_strobe, ch2_sample_strobe, ch2_cal_valid;
	logic [23:0] ch2_cal_data;
	int ref_at, ch2_at, ref_tick, ch2_tick, n_tick, n_ref, n_ch2;
	localparam int MOD_DIV_TB = 4;
	int n_mismatch, n_checks, cyc, i;
	logic [7:0] at [6] = '{8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'h58};
	logic [15:0] rt [6] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000};
	logic [15:0] ot [6] = '{16'hFFFF, 16'hFF00, 16'hFFF7, 16'hFFFF, 16'hFF00, 16'hFFFF};

	initial begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end
	adc_cal_regs #(.ADDR_W(8), .MOD_DIV(MOD_DIV_TB)) adc_cal_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .frame_start(frame_start), .ch2_raw_valid(ch2_raw_valid),
		.ch2_raw_data(ch2_raw_data), .ch1_gain_coef(ch1_gain_coef), .ch2_offset_coef(ch2_offset_coef),
		.ch2_gain_coef(ch2_gain_coef), .ch2_sample_delay(ch2_sample_delay), .temp_source_choice(temp_source_choice),
		.temp_measure_on(temp_measure_on), .temp_input_invert(temp_input_invert), .ch2_input_route(ch2_input_route),
		.mod_tick(mod_tick), .ref_sample_strobe(ref_sample_strobe), .ch2_sample_strobe(ch2_sample_strobe),
		.ch2_cal_valid(ch2_cal_valid), .ch2_cal_data(ch2_cal_data));
	apb_host apb_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	task automatic wrap_up();
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
		apb_host_inst.xfer(1'h0, a, 16'h0000, 4'h0, rd, er);
		chk(rd, {16'h0000, exp});
	endtask : rd_chk
	task automatic wr_lane(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
		apb_host_inst.xfer(1'h1, a, d, s, rd, er);
	endtask : wr_lane
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		wr_lane(a, d, 4'hF);
	endtask : wr
	// result stands from the first edge after the sample is taken
	task automatic cal_chk(input logic [23:0] raw, input logic [23:0] exp);
		ch2_raw_valid <= 1'h1;
		ch2_raw_data <= raw;
		@(posedge pclk);
		ch2_raw_valid <= 1'h0;
		repeat (2) @(posedge pclk);
		chk({7'h00, ch2_cal_valid, ch2_cal_data}, {8'h01, exp});
	endtask : cal_chk
	// only the lag against the reference strobe is fixed, not the bias behind it
	task automatic frame_chk(input logic [15:0] cfg, input int dly);
		wr(8'h4C, cfg);
		apb_host_inst.idle();
		frame_start <= 1'h1;
		@(posedge pclk);
		frame_start <= 1'h0;
		repeat (MOD_DIV_TB * 520) @(posedge pclk);
		chk(32'(ch2_at - ref_at), 32'(dly * MOD_DIV_TB));
		chk(32'(ch2_tick - ref_tick), 32'(dly));
	endtask : frame_chk
	task automatic do_reset();
		presetn <= 1'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
	endtask : do_reset

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	always @(posedge pclk) begin
		if (mod_tick === 1'h1) begin
			n_tick <= n_tick + 1;
		end
		if (ref_sample_strobe === 1'h1) begin
			ref_at <= cyc;
			ref_tick <= n_tick;
			n_ref <= n_ref + 1;
		end
		if (ch2_sample_strobe === 1'h1) begin
			ch2_at <= cyc;
			ch2_tick <= n_tick;
			n_ch2 <= n_ch2 + 1;
		end
	end

	initial begin
		presetn = 1'h0;
		frame_start = 1'h0;
		ch2_raw_valid = 1'h0;
		ch2_raw_data = 24'h0;
		do_reset();
		for (i = 0; i < 6; i++) rd_chk(at[i], rt[i]);
		apb_host_inst.idle();
		chk({8'h00, ch1_gain_coef}, 32'h00800000);
		// all ones back to back; reserved bits must stay clear
		for (i = 0; i < 6; i++) wr(at[i], 16'hFFFF);
		for (i = 0; i < 6; i++) rd_chk(at[i], ot[i]);
		rd_chk(8'h40, 16'h0000);
		chk({31'h0, er}, 32'h1);
		wr(8'h44, 16'hABCD);
		wr(8'h48, 16'h12EF);
		wr(8'h50, 16'h8001);
		wr(8'h54, 16'h7F55);
		wr(8'h58, 16'h1357);
		apb_host_inst.idle();
		chk({8'h00, ch1_gain_coef}, 32'h00ABCD12);
		chk({8'h00, ch2_offset_coef}, 32'h0080017F);
		chk({8'h00, ch2_gain_coef}, 32'h00135700);
		for (i = 0; i < 4; i++) begin
			v = {10'h200 + 10'(i), i[0], i[1], 1'h1, ~i[0], 2'(i)};
			wr(8'h4C, v);
			apb_host_inst.idle();
			chk({16'h0000, ch2_sample_delay, temp_source_choice, temp_measure_on, 1'h0, temp_input_invert,
				ch2_input_route}, {16'h0000, v & 16'hFFF7});
			rd_chk(8'h4C, v & 16'hFFF7);
		end
		apb_host_inst.idle();
		do_reset();
		chk({8'h00, ch2_gain_coef}, 32'h00800000);
		rd_chk(8'h54, 16'h0000);
		chk({31'h0, er}, 32'h0);
		apb_host_inst.idle();
		cal_chk(24'h123456, 24'h123456);
		wr_lane(8'h58, 16'h40AA, 4'h2);
		wr(8'h50, 16'h0001);
		rd_chk(8'h58, 16'h4000);
		apb_host_inst.idle();
		cal_chk(24'h123456, 24'h0919AB);
		wr_lane(8'h58, 16'h12FF, 4'h1);
		rd_chk(8'h58, 16'h40FF);
		wr(8'h58, 16'hFFFF);
		apb_host_inst.idle();
		cal_chk(24'h7FFFFF, 24'h7FFFFF);
		cal_chk(24'h800000, 24'h800000);
		frame_chk(16'h00C0, 3);
		frame_chk(16'hFF80, -2);
		chk(32'(n_ch2), 32'h2);
		chk(32'(n_ref), 32'h2);
		wrap_up();
	end
endmodule : testbench
